// ===== rtl/wtu_pkg.sv
/*
  Constants for the watchdog timer unit: register offsets, field positions,
  reset values and the machine-cycle divide.
  Assumes an 8-bit register port and the oscillator as the block clock.
*/
package wtu_pkg;
  // register offsets
  localparam logic [7:0] WTU_CTRL_OFS = 8'h8f; // watchdog_control
  localparam logic [7:0] WTU_PWR_OFS  = 8'h87; // power_control
  localparam logic [7:0] WTU_STS_OFS  = 8'h90; // interrupt status
  localparam logic [7:0] WTU_MSK_OFS  = 8'h91; // interrupt mask
  // watchdog_control fields
  localparam int WTU_EN_BIT   = 7; // watchdog_run_enable
  localparam int WTU_RST_BIT  = 6; // watchdog_restart
  localparam int WTU_IDLE_BIT = 5; // watchdog_idle_run
  localparam int WTU_PS_LSB   = 0; // prescale_sel_hi..lo, 3 bits
  // power_control fields
  localparam int WTU_IDL_BIT  = 0; // idle_request
  localparam int WTU_PD_BIT   = 1; // powerdown_request
  localparam int WTU_GF_LSB   = 2; // two general flags
  // status and mask fields
  localparam int WTU_EV_TOUT  = 0; // time-out happened
  localparam int WTU_EV_RSTD  = 1; // restart carried out
  // reset values
  localparam logic [7:0] WTU_CTRL_RST = 8'h00;
  localparam logic [7:0] WTU_PWR_RST  = 8'h00;
  localparam logic [1:0] WTU_STS_RST  = 2'h0;
  localparam logic [1:0] WTU_MSK_RST  = 2'h0;
  // timing: oscillator clocks per machine cycle, counter widths
  localparam int WTU_MC_DIV  = 12;
  localparam int WTU_TMR_W   = 14;
  localparam int WTU_PRE_W   = 8;
endpackage

// ===== rtl/wtu_watchdog.sv
/*
  Watchdog timer unit with idle and power-down control and an interrupt
  status/mask pair.
  Assumes CLK is the oscillator, all inputs are synchronous to CLK and the
  SYS_RESET pulse is fed back by the system into the device reset.
*/
// Local design decision: strobed register access.
`timescale 1ns/1ps
module wtu_watchdog
  import wtu_pkg::*;
#(
  parameter int TMR_W = WTU_TMR_W,
  parameter int PRE_W = WTU_PRE_W
) (
  // clock, reset, enable
  input  wire logic       CLK,
  input  wire logic       RST,
  input  wire logic       CE,
  // register port
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  // system side
  input  wire logic       WAKE_INT,
  output logic            SYS_RESET,
  output logic            CPU_HALT,
  output logic            OSC_HALT,
  output logic            IRQ
);

  typedef struct packed {
    logic [3:0]       mc;
    logic [PRE_W-1:0] pre;
    logic [TMR_W-1:0] tmr;
    logic             en;
    logic             restart;
    logic             idle_run;
    logic [2:0]       ps;
    logic             idle;
    logic             pd;
    logic             halt;
    logic [1:0]       gf;
    logic [1:0]       sts;
    logic [1:0]       msk;
    logic             irq;
    logic             sys_rst;
    logic [7:0]       rdata;
  } wtu_state_s;

  localparam logic [3:0] MC_LAST = 4'(WTU_MC_DIV - 1);

  wtu_state_s q;
  wtu_state_s next_q;

  logic             tick;
  logic             run;
  logic             pre_wrap;
  logic             timeout;
  logic [PRE_W-1:0] pre_top;
  logic [1:0]       ev;
  logic [7:0]       rd_mux;

  // divide ratio 2^(ps+1); 256 wraps to zero, so top becomes all ones
  assign pre_top = PRE_W'((PRE_W+1)'(2) << q.ps) - PRE_W'(1);
  // one machine cycle per twelve oscillator clocks; frozen in power-down
  assign tick = CE && !q.pd && (q.mc == MC_LAST);
  // counting gate: enable, not powered down, idle only if allowed
  assign run = q.en && !q.pd && (!q.idle || q.idle_run);
  assign pre_wrap = (q.pre == pre_top);
  // time-out on timer wrap from all ones
  assign timeout = tick && run && !q.restart && pre_wrap
                   && (&q.tmr);

  // read mux; reserved bits read as zero
  always_comb begin
    case (ADDR)
      WTU_CTRL_OFS: begin
        rd_mux = 8'h00;
        rd_mux[WTU_EN_BIT] = q.en;
        rd_mux[WTU_RST_BIT] = q.restart;
        rd_mux[WTU_IDLE_BIT] = q.idle_run;
        rd_mux[WTU_PS_LSB +: 3] = q.ps;
      end
      WTU_PWR_OFS: begin
        rd_mux = 8'h00;
        rd_mux[WTU_IDL_BIT] = q.idle;
        rd_mux[WTU_PD_BIT] = q.pd;
        rd_mux[WTU_GF_LSB +: 2] = q.gf;
      end
      WTU_STS_OFS: rd_mux = {6'h00, q.sts};
      WTU_MSK_OFS: rd_mux = {6'h00, q.msk};
      default:     rd_mux = 8'h00;
    endcase
  end

  // next-state logic for the whole block
  always_comb begin
    next_q = q;
    ev = 2'h0;
    if (CE) begin
      next_q.sys_rst = 1'b0;
      // machine-cycle divider stops with the oscillator
      if (!q.pd) begin
        next_q.mc = (q.mc == MC_LAST) ? 4'h0 : q.mc + 4'h1;
      end
      // restart is taken on the next machine cycle boundary
      if (tick && q.restart) begin
        next_q.pre = '0;
        next_q.tmr = '0;
        next_q.restart = 1'b0;
        ev[WTU_EV_RSTD] = 1'b1;
      end else if (tick && run) begin
        next_q.pre = pre_wrap ? '0 : q.pre + PRE_W'(1);
        if (pre_wrap) begin
          next_q.tmr = q.tmr + TMR_W'(1);
        end
      end
      // interrupt wakes the cpu from idle, never from power-down
      if (q.idle && !q.pd && WAKE_INT) begin
        next_q.idle = 1'b0;
      end
      // register writes
      if (WR) begin
        case (ADDR)
          WTU_CTRL_OFS: begin
            next_q.en = WDATA[WTU_EN_BIT];
            next_q.restart = WDATA[WTU_RST_BIT];
            next_q.idle_run = WDATA[WTU_IDLE_BIT];
            next_q.ps = WDATA[WTU_PS_LSB +: 3];
          end
          WTU_PWR_OFS: begin
            next_q.idle = WDATA[WTU_IDL_BIT];
            // power-down only sets here; the cpu cannot run to clear it
            next_q.pd = q.pd || WDATA[WTU_PD_BIT];
            next_q.gf = WDATA[WTU_GF_LSB +: 2];
          end
          WTU_MSK_OFS: next_q.msk = WDATA[1:0];
          default: begin
          end
        endcase
      end
      // time-out clears the control, power and counter fields over any write to them; mask is kept and status gains the time-out flag
      if (timeout) begin
        next_q.sys_rst = 1'b1;
        next_q.en = 1'b0;
        next_q.restart = 1'b0;
        next_q.idle_run = 1'b0;
        next_q.ps = 3'h0;
        next_q.pre = '0;
        next_q.tmr = '0;
        next_q.idle = 1'b0;
        next_q.pd = 1'b0;
        next_q.gf = 2'h0;
        ev[WTU_EV_TOUT] = 1'b1;
      end
      // halt kept in a flop so the output needs no gate after it
      next_q.halt = next_q.idle || next_q.pd;
      // read of status clears it, but a new event in that cycle wins
      next_q.sts = ((RD && ADDR == WTU_STS_OFS) ? 2'h0 : q.sts) | ev;
      next_q.irq = |(next_q.sts & next_q.msk);
      next_q.rdata = RD ? rd_mux : 8'h00;
    end
  end

  // single state register; async reset clears and disables all
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      q <= '0;
      q.en <= WTU_CTRL_RST[WTU_EN_BIT];
      q.idle_run <= WTU_CTRL_RST[WTU_IDLE_BIT];
      q.idle <= WTU_PWR_RST[WTU_IDL_BIT];
      q.pd <= WTU_PWR_RST[WTU_PD_BIT];
      q.halt <= WTU_PWR_RST[WTU_IDL_BIT] || WTU_PWR_RST[WTU_PD_BIT];
      q.sts <= WTU_STS_RST;
      q.msk <= WTU_MSK_RST;
    end else begin
      q <= next_q;
    end
  end

  // outputs straight from the state register
  assign RDATA = q.rdata;
  assign SYS_RESET = q.sys_rst;
  assign CPU_HALT = q.halt;
  assign OSC_HALT = q.pd;
  assign IRQ = q.irq;

  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  restart_clears_a: assert property (
    tick && q.restart && !(WR && ADDR == WTU_CTRL_OFS)
    |=> q.tmr == '0 && q.pre == '0 && !q.restart)
    else $error("restart did not clear timer and prescaler");

  stopped_hold_a: assert property (
    !q.en && !q.restart |=> $stable(q.tmr) && $stable(q.pre))
    else $error("timer moved while disabled");

  timeout_reset_a: assert property (
    timeout |=> SYS_RESET ##1 (!SYS_RESET || !$past(CE)))
    else $error("time-out gave no reset pulse");

  reset_cause_a: assert property (
    $rose(SYS_RESET) |-> $past(q.en) && $past(&q.tmr) && $past(pre_wrap))
    else $error("reset without a full time-out");

  prescale_wrap_a: assert property (
    tick && run && !q.restart && q.pre == pre_top && !(&q.tmr)
    |=> q.pre == '0 && q.tmr == $past(q.tmr) + TMR_W'(1))
    else $error("prescaler wrap did not step timer");

  machine_cycle_a: assert property (
    CE && !q.pd && q.mc != MC_LAST |=> $stable(q.pre) && $stable(q.tmr))
    else $error("counters moved inside a machine cycle");

  idle_stop_a: assert property (
    q.idle && !q.idle_run && !q.restart |=> $stable(q.tmr))
    else $error("watchdog counted in idle without idle-run");

  pd_freeze_a: assert property (
    q.pd && !timeout |=> $stable(q.mc) && OSC_HALT)
    else $error("clocks ran in power-down");

  reset_clean_a: assert property (
    SYS_RESET |-> !q.en && q.tmr == '0 && q.pre == '0)
    else $error("watchdog left running after its reset");

  idle_entry_a: assert property (
    CE && WR && ADDR == WTU_PWR_OFS && WDATA[WTU_IDL_BIT] && !timeout
    |=> CPU_HALT)
    else $error("idle request did not halt cpu");

  idle_wake_a: assert property (
    CE && q.idle && !q.pd && WAKE_INT && !WR |=> !q.idle)
    else $error("interrupt did not end idle");

  // counter and divider checks
  mc_range_a: assert property (
    q.mc <= MC_LAST)
    else $error("machine-cycle divider out of range");

  mc_wrap_a: assert property (
    CE && !q.pd && q.mc == MC_LAST |=> q.mc == 4'h0)
    else $error("machine-cycle divider did not wrap");

  pre_step_a: assert property (
    tick && run && !q.restart && !pre_wrap
    |=> q.pre == $past(q.pre) + PRE_W'(1) && $stable(q.tmr))
    else $error("prescaler did not step once per machine cycle");

  idle_count_a: assert property (
    tick && q.en && q.idle && q.idle_run && !q.pd && !q.restart
    |=> q.pre != $past(q.pre))
    else $error("watchdog stopped in idle with idle-run set");

  // register, mode and event checks
  restart_arm_a: assert property (
    CE && WR && ADDR == WTU_CTRL_OFS && WDATA[WTU_RST_BIT] && !timeout
    |=> q.restart)
    else $error("restart write was not taken");

  pd_hold_a: assert property (
    q.pd |=> q.pd)
    else $error("power-down ended without a reset");

  halt_match_a: assert property (
    CPU_HALT == (q.idle || q.pd))
    else $error("cpu halt disagrees with idle and power-down");

  timeout_clear_a: assert property (
    timeout |=> !q.en && !q.idle && !q.pd && q.ps == 3'h0)
    else $error("time-out left the watchdog configured");

  tout_flag_a: assert property (
    timeout |=> q.sts[WTU_EV_TOUT])
    else $error("time-out event not flagged");

  irq_match_a: assert property (
    IRQ == |(q.sts & q.msk))
    else $error("interrupt line disagrees with status and mask");

  cov_timeout_c: cover property (timeout);
  cov_restart_c: cover property (tick && q.restart);
  cov_wake_c:    cover property (q.idle && WAKE_INT);
  cov_irq_c:     cover property ($rose(IRQ));
  cov_pd_c:      cover property (q.pd && WAKE_INT);

endmodule // wtu_watchdog

// ===== testbench/tb_watchdog_timer_unit.sv
/*
  Self-checking bench for the watchdog timer unit: time-out per prescale
  code, restart, disable, idle and power-down, reset and register reads.
  Assumes wtu_pkg and wtu_watchdog are compiled first.
*/
`timescale 1ns/1ps
module tb_watchdog_timer_unit import wtu_pkg::*;;
  localparam int TW = 3; // short timer keeps all eight codes in budget
  logic            CLK, RST, CE, WR, RD, WAKE_INT;
  logic      [7:0] ADDR, WDATA;
  wire logic [7:0] RDATA;
  wire logic       SYS_RESET, CPU_HALT, OSC_HALT, IRQ;
  int              err_total, compares, n, p, g;

  wtu_watchdog #(.TMR_W(TW)) DUT (.CLK(CLK), .RST(RST), .CE(CE),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .WAKE_INT(WAKE_INT), .SYS_RESET(SYS_RESET), .CPU_HALT(CPU_HALT),
    .OSC_HALT(OSC_HALT), .IRQ(IRQ));

  // free-running 100 MHz clock
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  // hang guard, sized well above the longest time-out sweep
  initial begin
    #1_000_000;
    err_total++;
    results();
  end

  task automatic results();
    if (err_total == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge CLK);
    WR    <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge CLK);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge CLK);
    RD   <= 1'b0;
    #1 chk(RDATA, exp);
  endtask

  // counts watchdog reset pulses over a span
  task automatic run(input int cyc);
    repeat (cyc) begin
      @(posedge CLK);
      #1 if (SYS_RESET === 1'b1) n++;
    end
  endtask

  function automatic int period(input int c);
    return WTU_MC_DIV * (1 << TW) * (1 << (c + 1));
  endfunction

  function automatic logic [7:0] bit8(input logic b);
    return {7'h0, b};
  endfunction

  // main sequence
  initial begin
    RST <= 1'b1;
    CE  <= 1'b1;
    {WR, RD, WAKE_INT, ADDR, WDATA} <= 19'h0;
    n = $urandom(60);
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    rd(WTU_CTRL_OFS, WTU_CTRL_RST);
    rd(WTU_PWR_OFS, WTU_PWR_RST);
    rd(WTU_STS_OFS, 8'h00);
    wr(8'h55, 8'hff);
    rd(8'h55, 8'h00);
    g = $urandom % 4;
    wr(WTU_PWR_OFS, 8'(g << 2));
    rd(WTU_PWR_OFS, 8'(g << 2));
    wr(WTU_MSK_OFS, 8'h01);
    // time-out length for every prescale code
    for (int c = 0; c < 8; c++) begin
      p = period(c);
      wr(WTU_CTRL_OFS, 8'hc0 | 8'(c));
      n = 0;
      while (SYS_RESET !== 1'b1 && n < p + 40) begin
        @(posedge CLK);
        #1 n++;
      end
      chk(bit8(n >= p - 2 && n <= p + 16), 8'h01);
      @(posedge CLK);
      #1 chk(bit8(IRQ), 8'h01);
      rd(WTU_STS_OFS, 8'h03);
      chk(bit8(IRQ), 8'h00);
      rd(WTU_CTRL_OFS, 8'h00);
    end
    // restarts at random gaps keep the reset away
    p = period(0);
    wr(WTU_CTRL_OFS, 8'hc0);
    n = 0;
    repeat (8) begin
      run(p / 2 + $urandom % (p / 4));
      wr(WTU_CTRL_OFS, 8'hc0);
    end
    run(20);
    chk(8'(n), 8'h00);
    rd(WTU_CTRL_OFS, 8'h80);
    chk(bit8(IRQ), 8'h00);
    rd(WTU_STS_OFS, 8'h02);
    // clock enable low freezes a running watchdog
    wr(WTU_CTRL_OFS, 8'hc0);
    CE <= 1'b0;
    run(3 * p);
    @(posedge CLK);
    CE <= 1'b1;
    chk(8'(n), 8'h00);
    // disabled watchdog stays quiet
    wr(WTU_CTRL_OFS, 8'h40);
    run(3 * p);
    chk(8'(n), 8'h00);
    // idle without idle-run, then wake, then idle with idle-run
    wr(WTU_CTRL_OFS, 8'hc0);
    wr(WTU_PWR_OFS, 8'h01);
    run(3 * p);
    chk(8'(n), 8'h00);
    chk(bit8(CPU_HALT), 8'h01);
    @(posedge CLK);
    WAKE_INT <= 1'b1;
    @(posedge CLK);
    WAKE_INT <= 1'b0;
    @(posedge CLK);
    #1 chk(bit8(CPU_HALT), 8'h00);
    wr(WTU_CTRL_OFS, 8'he0);
    wr(WTU_PWR_OFS, 8'h01);
    run(p + 40);
    chk(8'(n), 8'h01);
    // power-down ignores wake and only reset ends it
    wr(WTU_CTRL_OFS, 8'hc0);
    wr(WTU_PWR_OFS, 8'h02);
    WAKE_INT <= 1'b1;
    run(3 * p);
    chk(8'(n), 8'h01);
    chk(bit8(OSC_HALT && CPU_HALT), 8'h01);
    @(posedge CLK);
    WAKE_INT <= 1'b0;
    RST      <= 1'b1;
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    #1 chk(bit8(OSC_HALT || CPU_HALT || IRQ), 8'h00);
    rd(WTU_CTRL_OFS, 8'h00);
    results();
  end
endmodule // tb_watchdog_timer_unit
